// ---- rtl/caf_acceptance_filter.sv ----
// Function
// RULE1 - sixteen filters each with extended low register
// RULE2 - filter bit value must equal message bit
// RULE3 - three masks with standard and extended registers
// RULE4 - mask bits 15:5 select standard identifier bits
// RULE5 - mask bits 1:0 and extended register select
// RULE6 - type bit set requires frame type match
// RULE7 - type bit clear accepts either frame type
// RULE8 - mask extended register fully read/write
// RULE9 - filter standard register field layout
// RULE10 - extended select chooses frame type; all must agree
// RULE11 - mask bits 4 and 2 read zero
`timescale 1ns/1ps
`default_nettype none
module caf_acceptance_filter
  import caf_pkg::*;
(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // protocol engine
  input  wire caf_rx_id_s  rx_id,
  output caf_result_s      rx_result,
  output logic             rx_result_valid
);
  // ==========================================================
  // storage
  logic [15:0] filt_std [NUM_FILTERS];
  logic [15:0] filt_ext [NUM_FILTERS];
  logic [15:0] mask_std [NUM_MASKS];
  logic [15:0] mask_ext [NUM_MASKS];
  logic [31:0] mask_sel;
  logic [15:0] filt_en;
  caf_result_s last_result;

  // ==========================================================
  // decode
  logic        acc;
  logic        wr;
  logic [3:0]  widx;
  logic        in_fstd;
  logic        in_fext;
  logic        in_mstd;
  logic        in_mext;
  logic        is_sel;
  logic        is_en;
  logic        is_st;
  logic        mapped;
  logic [15:0] lane;
  logic [15:0] wdat;
  logic [3:0]  eidx;

  // writes to unmapped or misaligned words are dropped
  assign acc     = psel && penable;
  assign wr      = acc && pwrite && mapped;
  assign widx    = paddr[5:2];
  // mask extended block is not on a 64-byte boundary, so index from its own base
  assign eidx    = 4'((paddr - MASK_EXT_BASE) / STRIDE);
  assign in_fstd = paddr >= FILT_STD_BASE && paddr < FILT_EXT_BASE;
  assign in_fext = paddr >= FILT_EXT_BASE && paddr < MASK_STD_BASE;
  assign in_mstd = paddr >= MASK_STD_BASE
                   && paddr < MASK_STD_BASE + STRIDE * 12'(NUM_MASKS);
  assign in_mext = paddr >= MASK_EXT_BASE
                   && paddr < MASK_EXT_BASE + STRIDE * 12'(NUM_MASKS);
  assign is_sel  = paddr == MASK_SEL_OFS;
  assign is_en   = paddr == FILT_EN_OFS;
  assign is_st   = paddr == STATUS_OFS;
  assign mapped  = paddr[1:0] == 2'h0
                   && (in_fstd || in_fext || in_mstd || in_mext || is_sel || is_en || is_st);
  assign lane    = {{8{pstrb[1]}}, {8{pstrb[0]}}};

  // ==========================================================
  // register writes
  genvar g;

  logic [NUM_FILTERS-1:0] we_fstd;
  logic [NUM_FILTERS-1:0] we_fext;
  logic [NUM_MASKS-1:0]   we_mstd;
  logic [NUM_MASKS-1:0]   we_mext;
  logic                   we_sel;
  logic                   we_en;

  // one strobe per register, raised in the access cycle only
  assign we_sel = wr && is_sel;
  assign we_en  = wr && is_en;

  generate
    for (g = 0; g < NUM_FILTERS; g++)
    begin : g_filt
      assign we_fstd[g] = wr && in_fstd && widx == 4'(g);
      assign we_fext[g] = wr && in_fext && widx == 4'(g);

      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          filt_std[g] <= REG_RST;
        else if (we_fstd[g])
          filt_std[g] <= (filt_std[g] & ~(lane & STD_WMASK))
                         | (pwdata[15:0] & lane & STD_WMASK);  // see RULE9
      end

      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          filt_ext[g] <= REG_RST;
        else if (we_fext[g])
          filt_ext[g] <= (filt_ext[g] & ~lane) | (pwdata[15:0] & lane);  // see RULE1
      end
    end
    for (g = 0; g < NUM_MASKS; g++)
    begin : g_mask
      assign we_mstd[g] = wr && in_mstd && widx == 4'(g);
      assign we_mext[g] = wr && in_mext && eidx == 4'(g);

      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          mask_std[g] <= REG_RST;
        else if (we_mstd[g])
          mask_std[g] <= (mask_std[g] & ~(lane & STD_WMASK))
                         | (pwdata[15:0] & lane & STD_WMASK);  // see RULE3 see RULE11
      end

      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          mask_ext[g] <= REG_RST;
        else if (we_mext[g])
          mask_ext[g] <= (mask_ext[g] & ~lane) | (pwdata[15:0] & lane);  // see RULE8
      end
    end
  endgenerate

  // mask select: every byte lane of the word is live
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      mask_sel <= MASK_SEL_RST;
    else if (we_sel)
    begin
      for (int b = 0; b < 4; b++)
      begin
        if (pstrb[b])
          mask_sel[b*8 +: 8] <= pwdata[b*8 +: 8];
      end
    end
  end

  // filter enables: low half only
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      filt_en <= FILT_EN_RST;
    else if (we_en)
      filt_en <= (filt_en & ~lane) | (pwdata[15:0] & lane);
  end

  // ==========================================================
  // read mux
  always_comb
  begin
    wdat = 16'h0000;
    if (in_fstd)
      wdat = filt_std[widx];
    else if (in_fext)
      wdat = filt_ext[widx];
    else if (in_mstd && widx < 4'(NUM_MASKS))
      wdat = mask_std[widx[1:0]] & STD_WMASK;  // see RULE11
    else if (in_mext && eidx < 4'(NUM_MASKS))
      wdat = mask_ext[eidx[1:0]];  // see RULE8
    else if (is_en)
      wdat = filt_en;
  end

  // access cycle always follows the setup cycle: no wait states
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pready <= 1'b0;
    else
      pready <= psel && !penable;
  end

  // error for unmapped or misaligned words, alongside pready
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pslverr <= 1'b0;
    else
      pslverr <= psel && !penable && !(paddr[1:0] == 2'h0 && mapped);
  end

  // read data captured at the setup edge and held until the next setup
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (psel && !penable)
    begin
      if (pwrite || !mapped)
        prdata <= 32'h0000_0000;
      else if (is_sel)
        prdata <= mask_sel;
      else if (is_st)
        prdata <= {23'h00_0000, last_result.hit, 4'h0, last_result.index};
      else
        prdata <= {16'h0000, wdat};
    end
  end

  // ==========================================================
  // acceptance compare
  logic [NUM_FILTERS-1:0] hits;
  caf_result_s            found;

  generate
    for (g = 0; g < NUM_FILTERS; g++)
    begin : g_cmp
      logic [1:0]  msel;
      logic [15:0] ms;
      logic [15:0] me;
      logic        m;
      assign msel = mask_sel[2*g +: 2];
      assign ms   = msel < 2'(NUM_MASKS) ? mask_std[msel] : 16'h0000;
      assign me   = msel < 2'(NUM_MASKS) ? mask_ext[msel] : 16'h0000;
      caf_filter_cmp u_cmp (
        .filt_std (filt_std[g]),
        .filt_ext (filt_ext[g]),
        .mask_std (ms),
        .mask_ext (me),
        .rx       (rx_id),
        .match    (m)
      );
      assign hits[g] = m && filt_en[g];  // see RULE10
    end
  endgenerate

  caf_hit_encoder #(.N(NUM_FILTERS)) u_enc (
    .hits   (hits),
    .result (found)
  );

  // one-cycle pulse, one edge after the identifier is taken
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rx_result_valid <= 1'b0;
    else
      rx_result_valid <= rx_id.valid;
  end

  // result held until the next identifier
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rx_result <= '0;
    else if (rx_id.valid)
      rx_result <= found;
  end

  // copy for the status register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      last_result <= '0;
    else if (rx_id.valid)
      last_result <= found;
  end
endmodule : caf_acceptance_filter
`default_nettype wire

// ---- common/caf_pkg.sv ----
`default_nettype none
package caf_pkg;
  localparam int NUM_FILTERS = 16;
  localparam int NUM_MASKS   = 3;
  localparam int FLT_IDX_W   = 4;
  localparam int MSK_IDX_W   = 2;
  localparam int STD_W       = 11;
  localparam int EXT_W       = 18;

  // register map (byte addresses)
  localparam logic [11:0] FILT_STD_BASE = 12'h000;
  localparam logic [11:0] FILT_EXT_BASE = 12'h040;
  localparam logic [11:0] MASK_STD_BASE = 12'h080;
  localparam logic [11:0] MASK_EXT_BASE = 12'h090;
  localparam logic [11:0] MASK_SEL_OFS  = 12'h0A0;
  localparam logic [11:0] FILT_EN_OFS   = 12'h0A4;
  localparam logic [11:0] STATUS_OFS    = 12'h0A8;
  localparam logic [11:0] STRIDE        = 12'h004;

  // standard register field layout
  localparam int SID_HI     = 15;
  localparam int SID_LO     = 5;
  localparam int TYPE_BIT   = 3;
  localparam int EXH_HI     = 1;
  localparam int EXH_LO     = 0;
  localparam logic [15:0] STD_WMASK = 16'hFFEB;

  // reset values chosen for defined simulation
  localparam logic [15:0] REG_RST      = 16'h0000;
  localparam logic [31:0] MASK_SEL_RST = 32'h0000_0000;
  localparam logic [15:0] FILT_EN_RST  = 16'hFFFF;

  // status layout
  localparam int ST_HIT_BIT = 8;
  localparam logic [4:0] NO_HIT = 5'h1F;

  typedef struct packed {
    logic        valid;
    logic        extended;
    logic [28:0] id;
  } caf_rx_id_s;

  typedef struct packed {
    logic       hit;
    logic [3:0] index;
  } caf_result_s;
endpackage : caf_pkg
`default_nettype wire

// ---- rtl/caf_filter_cmp.sv ----
`timescale 1ns/1ps
`default_nettype none
module caf_filter_cmp
  import caf_pkg::*;
(
  // filter and mask
  input  wire logic [15:0] filt_std,
  input  wire logic [15:0] filt_ext,
  input  wire logic [15:0] mask_std,
  input  wire logic [15:0] mask_ext,
  // received identifier
  input  wire caf_rx_id_s  rx,
  // outcome
  output logic             match
);
  logic [28:0] want;
  logic [28:0] care;
  logic        type_ok;
  logic        id_ok;

  always_comb
  begin
    // see RULE2 see RULE4 see RULE5 see RULE9
    want    = {filt_std[SID_HI:SID_LO], filt_std[EXH_HI:EXH_LO], filt_ext};
    care    = {mask_std[SID_HI:SID_LO], mask_std[EXH_HI:EXH_LO], mask_ext};
    id_ok   = ((want ^ rx.id) & care) == 29'h0000_0000;
    // see RULE6 see RULE7 see RULE10
    type_ok = !mask_std[TYPE_BIT] || (filt_std[TYPE_BIT] == rx.extended);
    match   = id_ok && type_ok;
  end
endmodule : caf_filter_cmp
`default_nettype wire

// ---- rtl/caf_hit_encoder.sv ----
`timescale 1ns/1ps
`default_nettype none
module caf_hit_encoder
  import caf_pkg::*;
#(
  parameter int N = NUM_FILTERS
)
(
  // per-filter matches
  input  wire logic [N-1:0] hits,
  // lowest matching filter
  output caf_result_s       result
);
  always_comb
  begin
    result = '0;
    for (int i = N - 1; i >= 0; i--)
    begin
      if (hits[i])
      begin
        result.hit   = 1'b1;
        result.index = 4'(i);
      end
    end
  end
endmodule : caf_hit_encoder
`default_nettype wire

// ---- bench/caf_can_engine_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// ==========
// protocol engine: one identifier per call
module caf_can_engine_model
  import caf_pkg::*;
(
  // clock
  input  wire logic       pclk,
  // identifier stream
  output var  caf_rx_id_s rx_id
);
  initial rx_id = '0;
  // valid for one cycle, then the lines show the inverse
  task automatic send(input logic ext, input logic [28:0] id);
    @(posedge pclk);
    rx_id <= '{valid: 1'b1, extended: ext, id: id};
    @(posedge pclk);
    rx_id <= '{valid: 1'b0, extended: ~ext, id: ~id};
  endtask : send
endmodule : caf_can_engine_model
`default_nettype wire

// ---- bench/caf_acceptance_filter_asserts.sv ----
`timescale 1ns/1ps
`default_nettype none
// ==========
// timing, miss-index and reserved-bit checks at the ports
module caf_acceptance_filter_asserts
  import caf_pkg::*;
(
  // clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  // protocol engine
  input wire caf_rx_id_s  rx_id,
  input wire caf_result_s rx_result,
  input wire logic        rx_result_valid
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_rdy; psel && !penable |=> pready; endproperty
  a_rdy: assert property (p_rdy) else $error("no pready after setup");
  property p_acc; pready |-> psel && penable; endproperty
  a_acc: assert property (p_acc) else $error("pready outside access");
  property p_err; pslverr |-> pready; endproperty
  a_err: assert property (p_err) else $error("pslverr without pready");
  property p_rxv; rx_id.valid |=> rx_result_valid; endproperty
  a_rxv: assert property (p_rxv) else $error("result late");
  property p_src; rx_result_valid |-> $past(rx_id.valid); endproperty
  a_src: assert property (p_src) else $error("result unasked");
  property p_nohit; rx_result_valid && !rx_result.hit |-> rx_result.index == 4'h0; endproperty
  a_nohit: assert property (p_nohit) else $error("index on miss");
  property p_hold; !rx_result_valid |-> $stable(rx_result); endproperty
  a_hold: assert property (p_hold) else $error("result moved");
  property p_rsvd; pready && !pwrite && (paddr < 12'h040 || paddr[11:4] == 8'h08)
    |-> prdata[4] == 1'b0 && prdata[2] == 1'b0; endproperty
  a_rsvd: assert property (p_rsvd) else $error("bits 4 2 set");
endmodule : caf_acceptance_filter_asserts
bind caf_acceptance_filter caf_acceptance_filter_asserts i_chk (.pclk, .presetn, .psel,
  .penable, .pwrite, .paddr, .pready, .prdata, .pslverr, .rx_id, .rx_result, .rx_result_valid);
`default_nettype wire

// ---- bench/can_acceptance_filter_mask_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
// ==========
// bench: registers, then random filtering
module can_acceptance_filter_mask_tb;
  import caf_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata;
  logic [3:0] pstrb = 4'hF;
  logic pready, pslverr, rx_result_valid, ext, hit, e;
  caf_rx_id_s rx_id;
  caf_result_s rx_result;
  int fail_count = 0, samples_checked = 0;
  logic [31:0] r = 32'd48, q;
  logic [15:0] fs, fe, ms, me;
  logic [28:0] id;
  logic [3:0] f;
  logic [1:0] mk;
  always #5 pclk = ~pclk;
  caf_acceptance_filter i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb, .pready, .prdata, .pslverr, .rx_id, .rx_result, .rx_result_valid);
  caf_can_engine_model i_eng (.pclk, .rx_id);
  function automatic logic [31:0] lfsr(logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr
  function automatic logic exp_hit(logic [15:0] a, b, c, d, logic x, logic [28:0] i);
    logic [28:0] v, m;
    v = {a[15:5], a[1:0], b};
    m = {c[15:5], c[1:0], d};
    return (((v ^ i) & m) == 29'h0) && (!c[3] || (x == a[3]));
  endfunction : exp_hit
  task automatic end_sim;
    if (fail_count == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : end_sim
  task automatic chk(string n, logic [31:0] x, logic [31:0] g);
    samples_checked++;
    if (g !== x) begin $display("BAD %s exp %h got %h", n, x, g); fail_count++; end
  endtask : chk
  task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 0; penable <= 0;
  endtask : apb
  task automatic rd(logic [11:0] a, logic [31:0] x);
    apb(0, a, 0);
    chk($sformatf("rd %h", a), x, q);
  endtask : rd
  initial begin #200000; fail_count++; end_sim; end
  initial
  begin
    repeat (4) @(posedge pclk);
    presetn <= 1;
    rd(MASK_EXT_BASE, 0);
    apb(1, MASK_STD_BASE + 12'h8, 32'hFFFF);
    rd(MASK_STD_BASE + 12'h8, 32'hFFEB);
    for (int i = 0; i < 16; i++)
    begin
      r = lfsr(r);
      apb(1, FILT_EXT_BASE + 12'(4 * i), r);
      apb(1, FILT_STD_BASE + 12'(4 * i), r >> 16);
      if (i < 3) apb(1, MASK_EXT_BASE + 12'(4 * i), ~r);
      rd(FILT_EXT_BASE + 12'(4 * i), {16'h0, r[15:0]});
      rd(FILT_STD_BASE + 12'(4 * i), {16'h0, r[31:16] & STD_WMASK});
      if (i < 3) rd(MASK_EXT_BASE + 12'(4 * i), {16'h0, ~r[15:0]});
    end
    apb(1, 12'hFFC, 32'h1234);
    chk("slverr", 1, e);
    rd(12'hFFC, 0);
    for (int t = 0; t < 60; t++)
    begin
      r = lfsr(r); f = r[3:0]; mk = 2'(r[5:4] % 3);
      r = lfsr(r); fs = r[15:0] & STD_WMASK; fe = r[31:16];
      r = lfsr(r); ms = t == 0 ? 16'h0 : t == 1 ? STD_WMASK : r[15:0] & STD_WMASK; me = r[31:16];
      apb(1, FILT_STD_BASE + 12'(4 * f), fs);
      apb(1, FILT_EXT_BASE + 12'(4 * f), fe);
      apb(1, MASK_STD_BASE + 12'(4 * mk), ms);
      apb(1, MASK_EXT_BASE + 12'(4 * mk), me);
      apb(1, MASK_SEL_OFS, 32'(mk) << (2 * f));
      apb(1, FILT_EN_OFS, 32'h1 << f);
      r = lfsr(r); ext = r[0];
      id = {fs[15:5], fs[1:0], fe} ^ (r[1] ? 29'h0 : 29'(r[31:8]));
      i_eng.send(ext, id);
      #1;
      hit = exp_hit(fs, fe, ms, me, ext, id);
      chk("rx_valid", 1, rx_result_valid);
      chk("rx_result", {hit, hit ? f : 4'h0}, rx_result);
      rd(STATUS_OFS, {23'h0, hit, 4'h0, hit ? f : 4'h0});
    end
    apb(1, MASK_SEL_OFS, 32'hFFFF_FFFF);
    apb(1, FILT_EN_OFS, 32'h0000_FFFF);
    rd(MASK_SEL_OFS, 32'hFFFF_FFFF);
    r = lfsr(r);
    i_eng.send(r[0], 29'(r));
    #1;
    chk("rx_lowest", {1'b1, 4'h0}, rx_result);
    rd(STATUS_OFS, {23'h0, 1'b1, 8'h00});
    pstrb <= 4'h1;
    apb(1, FILT_EN_OFS, 32'h0000_0000);
    pstrb <= 4'hF;
    rd(FILT_EN_OFS, 32'h0000_FF00);
    i_eng.send(r[1], ~29'(r));
    #1;
    chk("rx_upper", {1'b1, 4'h8}, rx_result);
    end_sim;
  end
endmodule : can_acceptance_filter_mask_tb
`default_nettype wire
